// [verilog/bcce_exec.v]
// bcce_exec.v: decode and execute of branch, call, clear, complement and compare-skip
// assumes: fetch presents instrWord for a whole instruction cycle and the next
// word (second call word, or the word after) in nextWord; data memory reads
// combinationally from dataAddr
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "bcce_defs.vh"
module bcce_exec (
   input wire sys_clk,
   input wire rst,
   input wire clkEn,
   input wire [15:0] instrWord,
   input wire [15:0] nextWord,
   input wire [7:0] dataRdata,
   input wire extEnable,
   input wire [11:0] indexBase,
   output wire [11:0] dataAddr,
   output reg [7:0] dataWdata,
   output reg dataWe,
   output reg [20:0] pc_q,
   output reg [20:0] returnStackTop,
   output reg stackPush,
   output reg [7:0] workReg_q,
   output reg [7:0] status_q,
   output reg [3:0] bankSelect_q,
   output reg [7:0] workShadow_q,
   output reg [7:0] statusShadow_q,
   output reg [3:0] bankShadow_q,
   output reg watchdogClear,
   output reg timeoutBit_q,
   output reg powerdownBit_q,
   output reg [1:0] idleLeft_q,
   output wire [1:0] phase,
   output wire cycleEnd
);
   localparam [1:0] IDLE_NONE = 2'h0;
   localparam [1:0] IDLE_ONE = 2'h1;
   localparam [1:0] IDLE_TWO = 2'h2;

   reg [7:0] opndLatch_q;
   reg [7:0] result_q;
   reg [20:0] pcNext;
   reg [1:0] idleNext;
   wire [7:0] op8;
   wire [7:0] fAddr;
   wire isBov;
   wire isBz;
   wire isCall;
   wire isClrf;
   wire isClrwdt;
   wire isComf;
   wire isCpfseq;
   wire branchTaken;
   wire nextTwoWord;
   wire executing;

   // detects the first word of a two-word instruction
   function isTwoWordFirst;
      input [15:0] w;
      begin
         isTwoWordFirst = (w[15:9] == `BCCE_OP_CALL);
      end
   endfunction

   function [20:0] branchTarget;
      input [20:0] pcv;
      input [7:0] off;
      begin
         branchTarget = pcv + 21'h000002 + {{12{off[7]}}, off, 1'b0};
      end
   endfunction

   bcce_phase_gen u_phase (
      .sys_clk(sys_clk),
      .rst(rst),
      .clkEn(clkEn),
      .phase_q(phase),
      .cycleEnd(cycleEnd)
   );

   assign op8 = instrWord[15:8];
   assign fAddr = instrWord[7:0];
   assign executing = (idleLeft_q == IDLE_NONE);
   assign isBov = executing && (op8 == `BCCE_OP_BOV);
   assign isBz = executing && (op8 == `BCCE_OP_BZ);
   assign isCall = executing && (instrWord[15:9] == `BCCE_OP_CALL);
   assign isClrf = executing && (instrWord[15:9] == `BCCE_OP_CLEAR_REGISTER_OP);
   assign isClrwdt = executing && (instrWord == `BCCE_OP_WATCHDOG_CLEAR_OP);
   assign isComf = executing && (instrWord[15:10] == `BCCE_OP_COMPLEMENT_REGISTER_OP);
   assign isCpfseq = executing && (instrWord[15:9] == `BCCE_OP_COMPARE_EQUAL_SKIP);
   assign branchTaken = (isBov && status_q[`BCCE_STATUS_OV]) ||
      (isBz && status_q[`BCCE_STATUS_Z]);
   assign nextTwoWord = isTwoWordFirst(nextWord);

   bcce_addr_gen u_addr (
      .fileAddr(fAddr),
      .accessBit(instrWord[8]),
      .bankSelect(bankSelect_q),
      .extEnable(extEnable),
      .indexBase(indexBase),
      .dataAddr(dataAddr)
   );

   // write strobe stands in Q4 so the address still belongs to this instruction
   always @* begin
      dataWe = !rst && cycleEnd && (isClrf || (isComf && instrWord[9]));
   end

   // end-of-cycle counter and idle-cycle bookkeeping
   always @* begin
      pcNext = pc_q + 21'h000002;
      idleNext = IDLE_NONE;
      if (!executing) begin
         // an idle cycle leaves the counter where the previous instruction put it
         pcNext = pc_q;
         idleNext = idleLeft_q - 2'h1;
      end else if (branchTaken) begin
         pcNext = branchTarget(pc_q, fAddr);
         idleNext = IDLE_ONE;
      end else if (isCall) begin
         pcNext = {nextWord[11:0], fAddr, 1'b0};
         idleNext = IDLE_ONE;
      end else if (isCpfseq && (dataRdata == workReg_q)) begin
         // skipped word and any second word go by as idle cycles
         pcNext = nextTwoWord ? pc_q + 21'h000006 : pc_q + 21'h000004;
         idleNext = nextTwoWord ? IDLE_TWO : IDLE_ONE;
      end else if (nextWord[15:12] == `BCCE_OP_SECOND && instrWord[15:12] == `BCCE_OP_SECOND) begin
         // a stray second word simply advances
         pcNext = pc_q + 21'h000002;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         pc_q <= `BCCE_PC_RESET;
         idleLeft_q <= IDLE_NONE;
         opndLatch_q <= 8'h00;
         result_q <= 8'h00;
         dataWdata <= 8'h00;
         returnStackTop <= 21'h000000;
         stackPush <= 1'b0;
         workReg_q <= 8'h00;
         status_q <= 8'h00;
         bankSelect_q <= 4'h0;
         workShadow_q <= 8'h00;
         statusShadow_q <= 8'h00;
         bankShadow_q <= 4'h0;
         watchdogClear <= 1'b0;
         timeoutBit_q <= 1'b1;
         powerdownBit_q <= 1'b1;
      end else if (clkEn) begin
         stackPush <= 1'b0;
         watchdogClear <= 1'b0;
         case (phase)
            `BCCE_PH_Q1: begin
               opndLatch_q <= 8'h00;
            end
            `BCCE_PH_Q2: begin
               opndLatch_q <= dataRdata;
            end
            `BCCE_PH_Q3: begin
               if (isClrf) begin
                  result_q <= 8'h00;
                  dataWdata <= 8'h00;
               end else begin
                  result_q <= ~opndLatch_q;
                  dataWdata <= ~opndLatch_q;
               end
               if (isCall) begin
                  returnStackTop <= pc_q + 21'h000004;
                  stackPush <= 1'b1;
                  if (instrWord[8]) begin
                     workShadow_q <= workReg_q;
                     statusShadow_q <= status_q;
                     bankShadow_q <= bankSelect_q;
                  end
               end
               if (isClrwdt) begin
                  watchdogClear <= 1'b1;
                  timeoutBit_q <= 1'b1;
                  powerdownBit_q <= 1'b1;
               end
            end
            default: begin
               // write back only in the last quarter
               if (isClrf) begin
                  status_q[`BCCE_STATUS_Z] <= 1'b1;
               end
               if (isComf) begin
                  status_q[`BCCE_STATUS_N] <= result_q[7];
                  status_q[`BCCE_STATUS_Z] <= (result_q == 8'h00);
                  if (!instrWord[9]) begin
                     workReg_q <= result_q;
                  end
               end
               pc_q <= pcNext;
               idleLeft_q <= idleNext;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// [include/bcce_defs.vh]
// bcce_defs.vh: opcode patterns, field positions, reset values and phase codes
// assumes: included by the bcce design files by bare name
`ifndef BCCE_DEFS_VH
`define BCCE_DEFS_VH
`define BCCE_OP_BOV 8'hE4
`define BCCE_OP_BZ 8'hE0
`define BCCE_OP_CALL 7'h76
`define BCCE_OP_CLEAR_REGISTER_OP 7'h35
`define BCCE_OP_WATCHDOG_CLEAR_OP 16'h0004
`define BCCE_OP_COMPLEMENT_REGISTER_OP 6'h07
`define BCCE_OP_COMPARE_EQUAL_SKIP 7'h31
`define BCCE_OP_SECOND 4'hF
`define BCCE_ACC_LIMIT 8'h5F
`define BCCE_ACC_HIGH_BANK 4'hF
`define BCCE_ACC_SPLIT 8'h60
`define BCCE_PC_RESET 21'h000000
`define BCCE_STATUS_N 4
`define BCCE_STATUS_OV 3
`define BCCE_STATUS_Z 2
`define BCCE_PH_Q1 2'h0
`define BCCE_PH_Q2 2'h1
`define BCCE_PH_Q3 2'h2
`define BCCE_PH_Q4 2'h3
`endif

// [verilog/bcce_phase_gen.v]
// bcce_phase_gen.v: quarter-phase counter, Q1..Q4 per instruction cycle
// assumes: one sys_clk per quarter phase, gated by clkEn
`timescale 1ns/10ps
`default_nettype none
`include "bcce_defs.vh"
module bcce_phase_gen (
   input wire sys_clk,
   input wire rst,
   input wire clkEn,
   output reg [1:0] phase_q,
   output wire cycleEnd
);
   assign cycleEnd = clkEn && (phase_q == `BCCE_PH_Q4);
   always @(posedge sys_clk) begin
      if (rst) begin
         phase_q <= `BCCE_PH_Q1;
      end else if (clkEn) begin
         phase_q <= phase_q + 2'h1;
      end
   end
endmodule
`default_nettype wire

// [verilog/bcce_addr_gen.v]
// bcce_addr_gen.v: data address forming for register-operand instructions
// assumes: bank select and index register come from the core
`timescale 1ns/10ps
`default_nettype none
`include "bcce_defs.vh"
module bcce_addr_gen (
   input wire [7:0] fileAddr,
   input wire accessBit,
   input wire [3:0] bankSelect,
   input wire extEnable,
   input wire [11:0] indexBase,
   output wire [11:0] dataAddr
);
   wire indexed;
   wire [11:0] accessAddr;
   wire [11:0] indexedAddr;
   // lower part of the access bank is bank 0, upper part is the special bank
   assign accessAddr = (fileAddr < `BCCE_ACC_SPLIT) ? {4'h0, fileAddr} :
      {`BCCE_ACC_HIGH_BANK, fileAddr};
   assign indexed = !accessBit && extEnable && (fileAddr <= `BCCE_ACC_LIMIT);
   assign indexedAddr = indexBase + {4'h0, fileAddr};
   assign dataAddr = indexed ? indexedAddr :
      (accessBit ? {bankSelect, fileAddr} : accessAddr);
endmodule
`default_nettype wire

// [verification/bcce_exec_props.sv]
// bcce_exec_props.sv: timing checks on the decode and execute block
// assumes: bound to bcce_exec, one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module bcce_exec_props (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic [15:0] instrWord,
   input wire logic [7:0] dataWdata,
   input wire logic dataWe,
   input wire logic [20:0] pc_q,
   input wire logic [7:0] status_q,
   input wire logic watchdogClear,
   input wire logic timeoutBit_q,
   input wire logic powerdownBit_q,
   input wire logic [1:0] idleLeft_q,
   input wire logic [1:0] phase,
   input wire logic cycleEnd
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire logic [20:0] brOff = {{12{instrWord[7]}}, instrWord[7:0], 1'b0};
   sequence s_exec(c);
      cycleEnd && idleLeft_q == 2'h0 && c;
   endsequence
   a_phase_step: assert property (
      clkEn |=> phase == $past(phase) + 2'h1) else $error("phase out of step");
   a_clear_write: assert property (
      s_exec(instrWord[15:9] == 7'h35) |-> ##[0:1] (dataWe && dataWdata == 8'h00))
      else $error("clear wrote no zero");
   a_ovf_untaken: assert property (
      s_exec(instrWord[15:8] == 8'hE4 && !status_q[3]) |=> pc_q == $past(pc_q) + 21'h2)
      else $error("untaken branch moved wrong");
   a_zero_taken: assert property (
      s_exec(instrWord[15:8] == 8'hE0 && status_q[2]) |=>
      idleLeft_q == 2'h1 && pc_q == $past(pc_q) + 21'h2 + $past(brOff))
      else $error("taken branch wrong");
   a_call_idle: assert property (
      s_exec(instrWord[15:9] == 7'h76) |=> idleLeft_q == 2'h1) else $error("call idle wrong");
   a_skip_flags: assert property (
      s_exec(instrWord[15:9] == 7'h31) |=> $stable(status_q)) else $error("compare hit flags");
   a_idle_hold: assert property (
      cycleEnd && idleLeft_q != 2'h0 |=> $stable(pc_q)) else $error("idle moved counter");
   a_wdt_bits: assert property (
      watchdogClear |-> ##[0:2] (timeoutBit_q && powerdownBit_q))
      else $error("watchdog bits not set");
endmodule
bind bcce_exec bcce_exec_props bcce_exec_props_inst (.sys_clk, .rst, .clkEn, .instrWord,
   .dataWdata, .dataWe, .pc_q, .status_q, .watchdogClear, .timeoutBit_q, .powerdownBit_q,
   .idleLeft_q, .phase, .cycleEnd);
`default_nettype wire

// [verification/bcce_data_mem.sv]
// bcce_data_mem.sv: data memory model on the far side
// assumes: read follows dataAddr at once, write on the edge with dataWe
`timescale 1ns/10ps
`default_nettype none
module bcce_data_mem (
   input wire logic sys_clk,
   input wire logic [11:0] dataAddr,
   input wire logic [7:0] dataWdata,
   input wire logic dataWe,
   output logic [7:0] dataRdata
);
   logic [7:0] mem [4096];
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = i[7:0];
   end
   assign dataRdata = mem[dataAddr];
   always @(posedge sys_clk) begin
      if (dataWe) mem[dataAddr] <= dataWdata;
   end
endmodule
`default_nettype wire

// [verification/bcce_exec_test.sv]
// bcce_exec_test.sv: self-checking bench for the execute block
// assumes: memory model starts with each byte equal to the low eight bits of its address
`timescale 1ns/10ps
`default_nettype none
module bcce_exec_test;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   logic extEnable = 1'b0;
   logic [15:0] instrWord = 16'h0000;
   logic [15:0] nextWord = 16'h0000;
   logic [11:0] dataAddr;
   logic [7:0] dataRdata, dataWdata, workReg_q, status_q, workShadow_q, statusShadow_q;
   logic [20:0] pc_q, returnStackTop;
   logic dataWe, timeoutBit_q, powerdownBit_q;
   logic [1:0] idleLeft_q;
   logic [67:0] rows [14];
   logic [20:0] lastPc = 21'h000000;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   bcce_exec bcce_exec_inst (.sys_clk, .rst, .clkEn, .instrWord, .nextWord, .dataRdata,
      .extEnable, .indexBase(12'h300), .dataAddr, .dataWdata, .dataWe, .pc_q, .returnStackTop,
      .stackPush(), .workReg_q, .status_q, .bankSelect_q(), .workShadow_q, .statusShadow_q,
      .bankShadow_q(), .watchdogClear(), .timeoutBit_q, .powerdownBit_q, .idleLeft_q,
      .phase(), .cycleEnd());
   bcce_data_mem bcce_data_mem_inst (.sys_clk, .dataAddr, .dataWdata, .dataWe, .dataRdata);
   initial forever #5 sys_clk = ~sys_clk;
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic run(input logic [67:0] r);
      instrWord <= r[67:52];
      nextWord <= r[51:36];
      extEnable <= r[35];
      @(negedge sys_clk);
      if (r[34:23] !== 12'hFFF) chk(dataAddr, r[34:23]);
      chk(pc_q, lastPc);
      repeat (4) @(posedge sys_clk);
      if (r[22:21] != 2'h0) begin
         @(negedge sys_clk);
         chk(idleLeft_q, r[22:21]);
         repeat (4 * r[22:21]) @(posedge sys_clk);
      end
      lastPc = r[20:0];
      $display("row done");
   endtask
   initial begin
      rows = '{{16'h1F10, 16'h0000, 1'h0, 12'h010, 2'h0, 21'h000002},
         {16'h1D20, 16'h0000, 1'h0, 12'h020, 2'h0, 21'h000004},
         {16'h63DF, 16'h0000, 1'h0, 12'h0DF, 2'h1, 21'h000008},
         {16'h63DE, 16'h0000, 1'h0, 12'h0DE, 2'h0, 21'h00000A},
         {16'h63DF, 16'hEC00, 1'h0, 12'h0DF, 2'h2, 21'h000010},
         {16'h6A70, 16'h0000, 1'h0, 12'hF70, 2'h0, 21'h000012},
         {16'hE0FE, 16'h0000, 1'h0, 12'hFFF, 2'h1, 21'h000010},
         {16'hE405, 16'h0000, 1'h0, 12'hFFF, 2'h0, 21'h000012},
         {16'h6A30, 16'h0000, 1'h1, 12'h330, 2'h0, 21'h000014},
         {16'hED45, 16'hF123, 1'h0, 12'hFFF, 2'h1, 21'h02468A},
         {16'h0004, 16'h0000, 1'h0, 12'hFFF, 2'h0, 21'h02468C},
         {16'hF123, 16'h0000, 1'h0, 12'hFFF, 2'h0, 21'h02468E},
         {16'h1D05, 16'h0000, 1'h0, 12'h005, 2'h0, 21'h024690},
         {16'hEC00, 16'hF001, 1'h0, 12'hFFF, 2'h1, 21'h000200}};
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 14; i++) run(rows[i]);
      @(negedge sys_clk);
      chk(pc_q, lastPc);
      chk(workReg_q, 8'hFA);
      chk(status_q, 8'h10);
      chk(workShadow_q, 8'hDF);
      chk(statusShadow_q, 8'h14);
      chk(returnStackTop, 21'h024694);
      chk({timeoutBit_q, powerdownBit_q}, 2'h3);
      chk(bcce_data_mem_inst.mem[12'h010], 8'hEF);
      chk(bcce_data_mem_inst.mem[12'hF70], 8'h00);
      chk(bcce_data_mem_inst.mem[12'h330], 8'h00);
      @(posedge sys_clk);
      clkEn <= 1'b0;
      instrWord <= 16'hE405;
      repeat (8) @(posedge sys_clk);
      clkEn <= 1'b1;
      @(negedge sys_clk);
      chk(pc_q, 21'h000200);
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(pc_q, 21'h000202);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(pc_q, 21'h000000);
      $display("hand tests done");
      stop_test();
   end
endmodule
`default_nettype wire
